// ### hdl/lockout_defs.svh
// Purpose: constants for the fault lockout monitor
// Assumes: register numbers are used directly as register addresses
// Notes: definitions only
`ifndef LOCKOUT_DEFS_SVH
`define LOCKOUT_DEFS_SVH

// ****************************************************************
// register numbers
// ****************************************************************
`define REG_S1_TALLY 16'h9D45
`define REG_S1_LIMIT 16'h9D46
`define REG_S1_PERIOD 16'h9D47
`define REG_S2_TALLY 16'h9D48
`define REG_S2_LIMIT 16'h9D49
`define REG_S2_PERIOD 16'h9D4A
`define REG_S3_TALLY 16'h9D4B
`define REG_S3_LIMIT 16'h9D4C
`define REG_S3_PERIOD 16'h9D4D
`define REG_S2_SEL_A 16'h9D52
`define REG_S2_SEL_B 16'h9D53
`define REG_S2_SEL_CTRL 16'h9D54
`define REG_S2_SEL_BRG 16'h9D55
`define REG_S3_SEL_A 16'h9D56
`define REG_S3_SEL_B 16'h9D57
`define REG_S3_SEL_CTRL 16'h9D58
`define REG_S3_SEL_BRG 16'h9D59
`define REG_CLEAR 16'hA3A7
`define REG_LOCK_STAT 16'h9D5A

// ****************************************************************
// reset values, access, limits
// ****************************************************************
`define LIMIT_RST 16'h0003
`define PERIOD_RST 16'h003C
`define SEL_RST 16'h0000
`define CLEAR_RST 16'h0000
`define CLEAR_MAX 16'h0001
`define CLEAR_GO 16'h0001
`define WR_LEVEL 2'h2
`define TALLY_MAX 16'hFFFF
`define ONE16 16'h0001

// ****************************************************************
// fixed first-slot selection and summary bit positions
// ****************************************************************
`define S1_SEL_A 16'h007F
`define SUM_SENSOR_BIT 14
`define SUM_CTRL_BIT 15
`define SUM_BEARING_BIT 15

`endif

// ### hdl/lockout_pkg.sv
// Purpose: types for the fault lockout monitor
// Assumes: nothing
// Notes: constants live in lockout_defs.svh
package lockout_pkg;
    typedef logic [15:0] word_t;
    typedef logic [1:0] level_t;
    typedef enum logic [1:0] {
        CLR_IDLE = 2'b00,
        CLR_ARMED = 2'b01,
        CLR_RESET = 2'b10
    } clear_state_e;
endpackage

// ### hdl/fault_lockout_monitor.sv
// Purpose: counts selected faults per slot and locks the compressor out
// Assumes: fault words and strobes come from logic on MCLK
// Notes: RESET stands for the power cycle, the only way out of lockout
`timescale 1ns/10ps
`include "lockout_defs.svh"
`default_nettype none

module fault_lockout_monitor (
    input wire logic MCLK,
    input wire logic RESET,
    input wire lockout_pkg::word_t FAULT_WORD_A,
    input wire lockout_pkg::word_t FAULT_WORD_B,
    input wire lockout_pkg::word_t CTRL_FAULTS,
    input wire lockout_pkg::word_t BEARING_FAULTS,
    input wire logic INVERTER_ERROR,
    input wire logic TIME_TICK,
    input wire logic FAULT_MODE,
    input wire logic RESET_DONE,
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire lockout_pkg::word_t REG_ADDR,
    input wire lockout_pkg::word_t REG_WDATA,
    input wire lockout_pkg::level_t ACCESS_LEVEL,
    output lockout_pkg::word_t REG_RDATA,
    output logic REG_ACK,
    output logic REG_ERR,
    output logic LOCKOUT,
    output logic FULL_RESET,
    output logic INLET_VANE_INIT,
    output logic READY_FOR_DEMAND
);
    import lockout_pkg::*;

    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic logic slot_hit(
        input word_t ra, input word_t rb, input word_t rc,
        input word_t rd, input word_t sa, input word_t sb,
        input word_t sc, input word_t sd);
        slot_hit = (|(ra & sa)) | (|(rb & sb)) | (|(rc & sc))
            | (|(rd & sd));
    endfunction

    function automatic word_t sat_inc(input word_t v);
        if (v == `TALLY_MAX) begin
            sat_inc = v;
        end else begin
            sat_inc = v + `ONE16;
        end
    endfunction

    // ****************************************************************
    // storage
    // ****************************************************************
    word_t tally_r [0:2];
    word_t limit_r [0:2];
    word_t period_r [0:2];
    word_t timer_r [0:2];
    logic running_r [0:2];
    word_t sel_a_r [1:2];
    word_t sel_b_r [1:2];
    word_t sel_c_r [1:2];
    word_t sel_d_r [1:2];
    word_t prev_a_r;
    word_t prev_b_r;
    word_t prev_c_r;
    word_t prev_d_r;
    word_t clear_r;
    logic lockout_r;
    clear_state_e clr_state_r;
    clear_state_e clr_state_nxt;
    word_t eff_a;
    word_t eff_c;
    word_t rise_a;
    word_t rise_b;
    word_t rise_c;
    word_t rise_d;
    logic hit [0:2];
    logic trip;
    logic wr_ok;
    logic wr_map;
    logic rd_map;
    word_t rd_val;
    logic clear_wr;

    // ****************************************************************
    // summary bits and new fault edges
    // ****************************************************************
    always_comb begin
        eff_a = FAULT_WORD_A;
        eff_c = CTRL_FAULTS;
        eff_a[`SUM_SENSOR_BIT] = FAULT_WORD_A[`SUM_SENSOR_BIT]
            | (|FAULT_WORD_B);
        eff_a[`SUM_CTRL_BIT] = FAULT_WORD_A[`SUM_CTRL_BIT]
            | (|CTRL_FAULTS) | (|BEARING_FAULTS);
        eff_c[`SUM_BEARING_BIT] = CTRL_FAULTS[`SUM_BEARING_BIT]
            | (|BEARING_FAULTS);
    end

    // after power returns prev is zero, so a present fault counts again
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            prev_a_r <= `SEL_RST;
            prev_b_r <= `SEL_RST;
            prev_c_r <= `SEL_RST;
            prev_d_r <= `SEL_RST;
        end else begin
            prev_a_r <= eff_a;
            prev_b_r <= FAULT_WORD_B;
            prev_c_r <= eff_c;
            prev_d_r <= BEARING_FAULTS;
        end
    end

    assign rise_a = eff_a & ~prev_a_r;
    assign rise_b = FAULT_WORD_B & ~prev_b_r;
    assign rise_c = eff_c & ~prev_c_r;
    assign rise_d = BEARING_FAULTS & ~prev_d_r;

    // ****************************************************************
    // slot qualification
    // ****************************************************************
    always_comb begin
        hit[0] = slot_hit(rise_a, rise_b, rise_c, rise_d,
            `S1_SEL_A, `SEL_RST, `SEL_RST, `SEL_RST);
        hit[1] = slot_hit(rise_a, rise_b, rise_c, rise_d,
            sel_a_r[1], sel_b_r[1], sel_c_r[1], sel_d_r[1]);
        hit[2] = slot_hit(rise_a, rise_b, rise_c, rise_d,
            sel_a_r[2], sel_b_r[2], sel_c_r[2], sel_d_r[2]);
    end

    // ****************************************************************
    // register write decode
    // ****************************************************************
    assign wr_ok = REG_WR && (ACCESS_LEVEL >= `WR_LEVEL);

    always_comb begin
        case (REG_ADDR)
            `REG_S1_LIMIT, `REG_S1_PERIOD, `REG_S2_LIMIT,
            `REG_S2_PERIOD, `REG_S3_LIMIT, `REG_S3_PERIOD,
            `REG_S2_SEL_A, `REG_S2_SEL_B, `REG_S2_SEL_CTRL,
            `REG_S2_SEL_BRG, `REG_S3_SEL_A, `REG_S3_SEL_B,
            `REG_S3_SEL_CTRL, `REG_S3_SEL_BRG: begin
                wr_map = 1'b1;
            end
            `REG_CLEAR: begin
                wr_map = (REG_WDATA <= `CLEAR_MAX);
            end
            default: begin
                wr_map = 1'b0;
            end
        endcase
    end

    assign clear_wr = wr_ok && (REG_ADDR == `REG_CLEAR) && wr_map;

    // ****************************************************************
    // slot configuration registers
    // ****************************************************************
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            for (int s = 0; s < 3; s++) begin
                limit_r[s] <= `LIMIT_RST;
                period_r[s] <= `PERIOD_RST;
            end
            for (int s = 1; s < 3; s++) begin
                sel_a_r[s] <= `SEL_RST;
                sel_b_r[s] <= `SEL_RST;
                sel_c_r[s] <= `SEL_RST;
                sel_d_r[s] <= `SEL_RST;
            end
        end else if (wr_ok) begin
            case (REG_ADDR)
                `REG_S1_LIMIT: limit_r[0] <= REG_WDATA;
                `REG_S1_PERIOD: period_r[0] <= REG_WDATA;
                `REG_S2_LIMIT: limit_r[1] <= REG_WDATA;
                `REG_S2_PERIOD: period_r[1] <= REG_WDATA;
                `REG_S3_LIMIT: limit_r[2] <= REG_WDATA;
                `REG_S3_PERIOD: period_r[2] <= REG_WDATA;
                `REG_S2_SEL_A: sel_a_r[1] <= REG_WDATA;
                `REG_S2_SEL_B: sel_b_r[1] <= REG_WDATA;
                `REG_S2_SEL_CTRL: sel_c_r[1] <= REG_WDATA;
                `REG_S2_SEL_BRG: sel_d_r[1] <= REG_WDATA;
                `REG_S3_SEL_A: sel_a_r[2] <= REG_WDATA;
                `REG_S3_SEL_B: sel_b_r[2] <= REG_WDATA;
                `REG_S3_SEL_CTRL: sel_c_r[2] <= REG_WDATA;
                `REG_S3_SEL_BRG: sel_d_r[2] <= REG_WDATA;
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // tallies and accumulate windows
    // ****************************************************************
    // a fault in the cycle the window ends keeps the running window open
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            for (int s = 0; s < 3; s++) begin
                tally_r[s] <= `SEL_RST;
                timer_r[s] <= `SEL_RST;
                running_r[s] <= 1'b0;
            end
        end else begin
            for (int s = 0; s < 3; s++) begin
                if (hit[s]) begin
                    tally_r[s] <= sat_inc(tally_r[s]);
                    if (!running_r[s]) begin
                        running_r[s] <= 1'b1;
                        timer_r[s] <= `SEL_RST;
                    end else if (TIME_TICK) begin
                        timer_r[s] <= sat_inc(timer_r[s]);
                    end
                end else if (running_r[s] && TIME_TICK) begin
                    if (sat_inc(timer_r[s]) >= period_r[s]
                        && !lockout_r) begin
                        tally_r[s] <= `SEL_RST;
                        timer_r[s] <= `SEL_RST;
                        running_r[s] <= 1'b0;
                    end else begin
                        timer_r[s] <= sat_inc(timer_r[s]);
                    end
                end
            end
        end
    end

    // ****************************************************************
    // lockout
    // ****************************************************************
    always_comb begin
        trip = INVERTER_ERROR;
        for (int s = 0; s < 3; s++) begin
            if (tally_r[s] > limit_r[s]) begin
                trip = 1'b1;
            end
        end
    end

    // only RESET, the power cycle, releases the lockout
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            lockout_r <= 1'b0;
        end else if (trip) begin
            lockout_r <= 1'b1;
        end
    end

    // ****************************************************************
    // clear faults register and full reset sequence
    // ****************************************************************
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            clear_r <= `CLEAR_RST;
        end else if (clear_wr && !lockout_r) begin
            clear_r <= REG_WDATA;
        end else if (clr_state_r == CLR_RESET && RESET_DONE) begin
            clear_r <= `CLEAR_RST;
        end else if (lockout_r) begin
            clear_r <= `CLEAR_RST;
        end
    end

    always_comb begin
        clr_state_nxt = clr_state_r;
        case (clr_state_r)
            CLR_IDLE: begin
                if (clear_wr && REG_WDATA == `CLEAR_GO && !lockout_r) begin
                    clr_state_nxt = CLR_ARMED;
                end
            end
            CLR_ARMED: begin
                if (lockout_r) begin
                    clr_state_nxt = CLR_IDLE;
                end else if (clear_r != `CLEAR_GO) begin
                    clr_state_nxt = CLR_IDLE;
                end else if (FAULT_MODE) begin
                    clr_state_nxt = CLR_RESET;
                end
            end
            CLR_RESET: begin
                if (RESET_DONE) begin
                    clr_state_nxt = CLR_IDLE;
                end
            end
            default: begin
                clr_state_nxt = CLR_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            clr_state_r <= CLR_IDLE;
        end else begin
            clr_state_r <= clr_state_nxt;
        end
    end

    // one-cycle pulse on entry to the reset phase
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            FULL_RESET <= 1'b0;
            INLET_VANE_INIT <= 1'b0;
        end else begin
            FULL_RESET <= (clr_state_r == CLR_ARMED)
                && (clr_state_nxt == CLR_RESET);
            INLET_VANE_INIT <= (clr_state_r == CLR_ARMED)
                && (clr_state_nxt == CLR_RESET);
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            READY_FOR_DEMAND <= 1'b0;
        end else begin
            READY_FOR_DEMAND <= !trip && !lockout_r
                && (clr_state_nxt != CLR_RESET);
        end
    end

    assign LOCKOUT = lockout_r;

    // ****************************************************************
    // register read and answer
    // ****************************************************************
    always_comb begin
        rd_map = 1'b1;
        case (REG_ADDR)
            `REG_S1_TALLY: rd_val = tally_r[0];
            `REG_S1_LIMIT: rd_val = limit_r[0];
            `REG_S1_PERIOD: rd_val = period_r[0];
            `REG_S2_TALLY: rd_val = tally_r[1];
            `REG_S2_LIMIT: rd_val = limit_r[1];
            `REG_S2_PERIOD: rd_val = period_r[1];
            `REG_S3_TALLY: rd_val = tally_r[2];
            `REG_S3_LIMIT: rd_val = limit_r[2];
            `REG_S3_PERIOD: rd_val = period_r[2];
            `REG_S2_SEL_A: rd_val = sel_a_r[1];
            `REG_S2_SEL_B: rd_val = sel_b_r[1];
            `REG_S2_SEL_CTRL: rd_val = sel_c_r[1];
            `REG_S2_SEL_BRG: rd_val = sel_d_r[1];
            `REG_S3_SEL_A: rd_val = sel_a_r[2];
            `REG_S3_SEL_B: rd_val = sel_b_r[2];
            `REG_S3_SEL_CTRL: rd_val = sel_c_r[2];
            `REG_S3_SEL_BRG: rd_val = sel_d_r[2];
            `REG_CLEAR: rd_val = clear_r;
            `REG_LOCK_STAT: rd_val = {15'h0000, lockout_r};
            default: begin
                rd_val = `SEL_RST;
                rd_map = 1'b0;
            end
        endcase
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= `SEL_RST;
            REG_ACK <= 1'b0;
            REG_ERR <= 1'b0;
        end else begin
            REG_ACK <= REG_RD || REG_WR;
            REG_ERR <= (REG_RD && !rd_map)
                || (REG_WR && !(wr_ok && wr_map));
            if (REG_RD) begin
                REG_RDATA <= rd_val;
            end
        end
    end

endmodule // fault_lockout_monitor

`default_nettype wire

// ### sim/lockout_chk.sv
// Purpose: port-level assertions for the fault lockout monitor
// Assumes: one clock domain, RESET asynchronous active high
// Notes: bound to every instance of the top module
`timescale 1ns/10ps
`default_nettype none
module lockout_chk (
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire logic INVERTER_ERROR,
    input wire logic FAULT_MODE,
    input wire logic REG_ACK,
    input wire logic LOCKOUT,
    input wire logic FULL_RESET,
    input wire logic INLET_VANE_INIT,
    input wire logic READY_FOR_DEMAND
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);
    a_ack_after_req: assert property ((REG_RD || REG_WR) |=> REG_ACK)
        else $error("no acknowledge after a request");
    a_ack_has_cause: assert property (
        REG_ACK |-> $past(REG_RD) || $past(REG_WR))
        else $error("acknowledge without a request");
    a_lockout_sticky: assert property (LOCKOUT |=> LOCKOUT)
        else $error("lockout released without power cycle");
    a_inverter_trip: assert property (INVERTER_ERROR |=> LOCKOUT)
        else $error("inverter error did not lock out");
    a_lock_blocks_ready: assert property (
        LOCKOUT |=> !READY_FOR_DEMAND)
        else $error("ready while locked out");
    a_vane_with_reset: assert property (
        (FULL_RESET || INLET_VANE_INIT)
        |-> (FULL_RESET && INLET_VANE_INIT))
        else $error("vane init not paired with full reset");
    a_reset_one_pulse: assert property (FULL_RESET |=> !FULL_RESET)
        else $error("full reset longer than one cycle");
    a_reset_needs_fault: assert property (
        FULL_RESET |-> $past(FAULT_MODE) || $past(FAULT_MODE, 2))
        else $error("full reset without fault mode");
    a_no_restart_locked: assert property (
        LOCKOUT && $past(LOCKOUT) |-> !FULL_RESET)
        else $error("full reset while locked out");
    c_lockout: cover property ($rose(LOCKOUT));
    c_full_reset: cover property (FULL_RESET);
    c_trip: cover property (INVERTER_ERROR ##1 LOCKOUT);
endmodule // lockout_chk
bind fault_lockout_monitor lockout_chk u_chk (.MCLK(MCLK), .RESET(RESET),
    .REG_RD(REG_RD), .REG_WR(REG_WR), .INVERTER_ERROR(INVERTER_ERROR),
    .FAULT_MODE(FAULT_MODE), .REG_ACK(REG_ACK), .LOCKOUT(LOCKOUT),
    .FULL_RESET(FULL_RESET), .INLET_VANE_INIT(INLET_VANE_INIT),
    .READY_FOR_DEMAND(READY_FOR_DEMAND));
`default_nettype wire

// ### sim/modbus_host.sv
// Purpose: register-bus controller model facing the lockout monitor
// Assumes: one request per call, answer registered on the taking edge itself
// Notes: address and data lines hold the inverted last request when idle
`timescale 1ns/10ps
`default_nettype none
module modbus_host (
    input wire logic MCLK,
    input wire logic REG_ACK,
    input wire logic REG_ERR,
    input wire lockout_pkg::word_t REG_RDATA,
    output logic REG_RD,
    output logic REG_WR,
    output lockout_pkg::word_t REG_ADDR,
    output lockout_pkg::word_t REG_WDATA,
    output lockout_pkg::level_t ACCESS_LEVEL
);
    import lockout_pkg::*;
    initial begin
        {REG_RD, REG_WR, ACCESS_LEVEL} = 4'h0;
        {REG_ADDR, REG_WDATA} = 32'h0000FFFF;
    end
    task automatic access(input logic w, input word_t a, input word_t d,
            input level_t lv, output word_t q, output logic ak,
            output logic er);
        @(posedge MCLK);
        #1;
        {REG_WR, REG_RD} = {w, !w};
        {REG_ADDR, REG_WDATA} = {a, d};
        ACCESS_LEVEL = lv;
        @(posedge MCLK);
        #1;
        {REG_WR, REG_RD} = 2'b00;
        {REG_ADDR, REG_WDATA} = {~a, ~d};
        {q, ak, er} = {REG_RDATA, REG_ACK, REG_ERR};
    endtask
endmodule // modbus_host
`default_nettype wire

// ### sim/testbench.sv
// Purpose: self-checking bench for the fault lockout monitor
// Assumes: registers reached through the controller model u_host
// Notes: reference model keeps expected register values in mreg
`timescale 1ns/10ps
`include "lockout_defs.svh"
`default_nettype none
module testbench;
    import lockout_pkg::*;
    logic MCLK, RESET, INVERTER_ERROR, TIME_TICK, FAULT_MODE, RESET_DONE;
    logic rd_s, wr_s, ack, err, lock, fres, vane, ready, qa, qe;
    word_t fw [4];
    word_t addr, wdata, rdata, q;
    level_t lvl;
    int err_count, compares, seed, n;
    int mreg [int];
    int timer [3];
    fault_lockout_monitor u_fault_lockout_monitor (
        .MCLK(MCLK), .RESET(RESET), .FAULT_WORD_A(fw[0]),
        .FAULT_WORD_B(fw[1]), .CTRL_FAULTS(fw[2]), .BEARING_FAULTS(fw[3]),
        .INVERTER_ERROR(INVERTER_ERROR), .TIME_TICK(TIME_TICK),
        .FAULT_MODE(FAULT_MODE), .RESET_DONE(RESET_DONE), .REG_RD(rd_s),
        .REG_WR(wr_s), .REG_ADDR(addr), .REG_WDATA(wdata),
        .ACCESS_LEVEL(lvl), .REG_RDATA(rdata), .REG_ACK(ack), .REG_ERR(err),
        .LOCKOUT(lock), .FULL_RESET(fres), .INLET_VANE_INIT(vane),
        .READY_FOR_DEMAND(ready));
    modbus_host u_host (
        .MCLK(MCLK), .REG_ACK(ack), .REG_ERR(err), .REG_RDATA(rdata),
        .REG_RD(rd_s), .REG_WR(wr_s), .REG_ADDR(addr), .REG_WDATA(wdata),
        .ACCESS_LEVEL(lvl));
    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end
    initial begin
        #1000000;
        err_count++;
        stop_test();
    end
    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic step();
        @(posedge MCLK);
        #1;
    endtask
    task automatic chk(input string nm, input word_t seen, input word_t exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic bit wok(input int a);
        return a inside {'h9D46, 'h9D47, 'h9D49, 'h9D4A, 'h9D4C, 'h9D4D,
            ['h9D52:'h9D59], 'hA3A7};
    endfunction
    function automatic int selw(input int s, input int w);
        if (s == 0)
            return w == 0 ? `S1_SEL_A : 0;
        return mreg['h9D4E + 4 * s + w];
    endfunction
    task automatic model_reset();
        mreg.delete();
        for (int s = 0; s < 3; s++) begin
            mreg['h9D45 + 3 * s] = 0;
            mreg['h9D46 + 3 * s] = `LIMIT_RST;
            mreg['h9D47 + 3 * s] = `PERIOD_RST;
            timer[s] = 0;
        end
        for (int a = 'h9D52; a <= 'h9D5A; a++)
            mreg[a] = 0;
        mreg['hA3A7] = `CLEAR_RST;
    endtask
    task automatic power(input logic inv);
        step();
        RESET = 1'b1;
        INVERTER_ERROR = inv;
        repeat (4) @(posedge MCLK);
        #1;
        RESET = 1'b0;
        model_reset();
        mreg['h9D5A] = inv;
        step();
    endtask
    task automatic rd(input int a);
        u_host.access(1'b0, a[15:0], 16'h0000, 2'h0, q, qa, qe);
        chk("ack", {15'h0000, qa}, 16'h0001);
        chk("read err", {15'h0000, qe}, {15'h0000, !mreg.exists(a)});
        chk($sformatf("reg %h", a), q,
            mreg.exists(a) ? word_t'(mreg[a]) : 16'h0000);
    endtask
    task automatic wr(input int a, input int d, input int lv);
        bit ok;
        ok = lv >= 2 && wok(a) && !(a == 'hA3A7 && d[15:0] > 1);
        u_host.access(1'b1, a[15:0], d[15:0], lv[1:0], q, qa, qe);
        chk("write err", {15'h0000, qe}, {15'h0000, !ok});
        if (ok && !(a == 'hA3A7 && mreg['h9D5A] != 0))
            mreg[a] = d & 'hFFFF;
    endtask
    task automatic pulse(input int w, input int v);
        int e [4];
        step();
        fw[w] = v[15:0];
        step();
        fw[w] = 16'h0000;
        e = '{default: 0};
        e[w] = v & 'hFFFF;
        e[0] |= (int'(e[1] != 0) << `SUM_SENSOR_BIT)
            | (int'((e[2] | e[3]) != 0) << `SUM_CTRL_BIT);
        e[2] |= int'(e[3] != 0) << `SUM_BEARING_BIT;
        for (int s = 0; s < 3; s++)
            if ((e[0] & selw(s, 0) | e[1] & selw(s, 1) | e[2] & selw(s, 2)
                | e[3] & selw(s, 3)) != 0) begin
                if (mreg['h9D45 + 3 * s] == 0)
                    timer[s] = 0;
                mreg['h9D45 + 3 * s]++;
                if (mreg['h9D45 + 3 * s] > mreg['h9D46 + 3 * s])
                    mreg['h9D5A] = 1;
            end
    endtask
    task automatic tick();
        step();
        TIME_TICK = 1'b1;
        step();
        TIME_TICK = 1'b0;
        for (int s = 0; s < 3; s++)
            if (mreg['h9D45 + 3 * s] > 0) begin
                if (timer[s] + 1 >= mreg['h9D47 + 3 * s]
                    && mreg['h9D5A] == 0) begin
                    mreg['h9D45 + 3 * s] = 0;
                    timer[s] = 0;
                end else
                    timer[s]++;
            end
    endtask
    initial begin
        seed = 36;
        {err_count, compares} = 0;
        fw = '{default: 16'h0000};
        {INVERTER_ERROR, TIME_TICK, FAULT_MODE, RESET_DONE} = 4'h0;
        RESET = 1'b1;
        power(1'b0);
        chk("ready", {15'h0000, ready}, 16'h0001);
        for (int a = 'h9D45; a <= 'h9D5A; a++)
            rd(a);
        rd('hA3A7);
        $display("reset values done");
        for (int a = 'h9D45; a <= 'h9D59; a++) begin
            wr(a, $random(seed), 2);
            rd(a);
        end
        wr('h9D46, 5, 1);
        wr('hA3A7, 2, 2);
        wr('hA3A7, 1, 1);
        rd('h9D46);
        rd('hA3A7);
        for (int a = 'h9D52; a <= 'h9D59; a++)
            wr(a, 0, 2);
        $display("register access done");
        wr('h9D46, 7, 2);
        for (int b = 0; b < 7; b++)
            pulse(0, 1 << b);
        pulse(0, 'h0180);
        rd('h9D45);
        chk("lockout", {15'h0000, lock}, 16'h0000);
        pulse(0, 'h0003);
        step();
        chk("lockout", {15'h0000, lock}, 16'h0001);
        chk("ready", {15'h0000, ready}, 16'h0000);
        rd('h9D45);
        rd('h9D5A);
        wr('hA3A7, 1, 2);
        rd('hA3A7);
        FAULT_MODE = 1'b1;
        n = 0;
        repeat (10) begin
            step();
            if (fres !== 1'b0)
                n++;
        end
        FAULT_MODE = 1'b0;
        chk("restarts", n[15:0], 16'h0000);
        chk("lockout", {15'h0000, lock}, 16'h0001);
        $display("count lockout done");
        power(1'b1);
        chk("lockout", {15'h0000, lock}, 16'h0001);
        power(1'b0);
        chk("lockout", {15'h0000, lock}, 16'h0000);
        rd('h9D45);
        step();
        INVERTER_ERROR = 1'b1;
        step();
        INVERTER_ERROR = 1'b0;
        chk("trip", {15'h0000, lock}, 16'h0001);
        power(1'b0);
        $display("power cycle done");
        wr('h9D49, 10, 2);
        wr('h9D4A, 2, 2);
        wr('h9D53, 'h0004, 2);
        wr('h9D54, 'h0002 + 'h0020, 2);
        wr('h9D55, 'h0008, 2);
        wr('h9D59, 'h0010, 2);
        pulse(1, 'h000C);
        pulse(2, 'h0020);
        pulse(3, 'h0018);
        pulse(0, 'h0001);
        for (int a = 'h9D45; a <= 'h9D4B; a += 3)
            rd(a);
        tick();
        rd('h9D48);
        tick();
        rd('h9D48);
        rd('h9D45);
        repeat (4)
            pulse(1 + ($random(seed) & 1), $random(seed));
        rd('h9D48);
        wr('h9D56, 'hC000, 2);
        pulse(1, 'h0200);
        pulse(3, 'h0001);
        rd('h9D4B);
        $display("slot selection done");
        wr('hA3A7, 1, 2);
        rd('hA3A7);
        FAULT_MODE = 1'b1;
        n = 0;
        while (fres !== 1'b1 && n < 10) begin
            step();
            n++;
        end
        chk("full reset", {15'h0000, fres}, 16'h0001);
        chk("vane init", {15'h0000, vane}, 16'h0001);
        chk("ready", {15'h0000, ready}, 16'h0000);
        FAULT_MODE = 1'b0;
        step();
        RESET_DONE = 1'b1;
        step();
        RESET_DONE = 1'b0;
        step();
        chk("ready", {15'h0000, ready}, 16'h0001);
        mreg['hA3A7] = 0;
        rd('hA3A7);
        $display("clear sequence done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
